// [jtag_isp_defines.svh]
// Constants of the test access and in-system programming port
`ifndef JTAG_ISP_DEFINES_SVH
`define JTAG_ISP_DEFINES_SVH

// ----------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------
`define IR_W 5
`define IR_CAPTURE 5'h01
`define INS_EXTEST 5'h00
`define INS_IDCODE 5'h01
`define INS_SAMPLE 5'h02
`define INS_INTEST 5'h03
`define INS_HIGHZ 5'h05
`define INS_ISP_ENABLE 5'h09
`define INS_ISP_ERASE 5'h0A
`define INS_ISP_PROGRAM 5'h0B
`define INS_ISP_VERIFY 5'h0C
`define INS_ISP_DISABLE 5'h10
`define INS_BYPASS 5'h1F

// ----------------------------------------------------------------
// Data registers and configuration array
// ----------------------------------------------------------------
`define ID_W 32
// Identification value is arbitrary
`define IDCODE_DEF 32'h0A5A_5001
`define BSR_LEN_DEF 8
`define ROW_W_DEF 16
`define ADDR_W_DEF 3
`define ADDR_W_MAX 8
`define CFG_ROW 0
`define CFG_IO_BIT 0

`endif

// [jtag_isp_pkg.sv]
// Types shared by the test port files
package jtag_isp_pkg;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR = 4'b1111, RTI = 4'b1100, SEL_DR = 4'b0111, CAP_DR = 4'b0110,
    SH_DR = 4'b0010, EX1_DR = 4'b0001, PA_DR = 4'b0011, EX2_DR = 4'b0000,
    UP_DR = 4'b0101, SEL_IR = 4'b0100, CAP_IR = 4'b1110, SH_IR = 4'b1010,
    EX1_IR = 4'b1001, PA_IR = 4'b1011, EX2_IR = 4'b1000, UP_IR = 4'b1101
  } tap_state_e;

  // ----------------------------------------------------------------
  // Pin modes and data register choice
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BS_FUNC = 2'b00, BS_DRIVE = 2'b01, BS_HIGHZ = 2'b10, BS_INTEST = 2'b11
  } bs_mode_e;

  typedef enum logic [1:0] {
    DR_BYP = 2'b00, DR_ID = 2'b01, DR_BSR = 2'b10, DR_ISP = 2'b11
  } dr_sel_e;

  typedef struct packed {
    bs_mode_e mode;
    logic isp_on;
    logic port_on;
  } port_ctl_s;

endpackage : jtag_isp_pkg

// [jtag_sync2.sv]
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module jtag_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  if (W < 1) begin : g_chk
    $error("jtag_sync2: width must be positive");
  end

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    if (rst) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign q = st_r.s2;
endmodule : jtag_sync2

// [jtag_isp_test_port.sv]
// Test access port with boundary scan and in-system programming
`timescale 1ns/10ps
`include "jtag_isp_defines.svh"
module jtag_isp_test_port #(
  parameter int BSR_LEN = `BSR_LEN_DEF,
  parameter int ROW_W = `ROW_W_DEF,
  parameter int ADDR_W = `ADDR_W_DEF,
  parameter logic [`ID_W-1:0] IDCODE = `IDCODE_DEF
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic port_en,
  input wire logic [BSR_LEN-1:0] user_out,
  input wire logic [BSR_LEN-1:0] user_oe,
  input wire logic [BSR_LEN-1:0] pin_in,
  input wire logic mc_logic_in,
  output logic tdo,
  output logic tdo_oe,
  output logic pin_test_mode,
  output logic isp_active,
  output logic [BSR_LEN-1:0] sys_out,
  output logic [BSR_LEN-1:0] sys_oe,
  output logic [BSR_LEN-1:0] core_in,
  output logic mc_logic_out
);
  import jtag_isp_pkg::*;

  localparam int ISP_LEN = ADDR_W + ROW_W;
  localparam int ROWS = 2 ** ADDR_W;

  if (BSR_LEN < 2 || ROW_W < 1 || ADDR_W < 1 || ADDR_W > `ADDR_W_MAX) begin : g_chk
    $error("jtag_isp_test_port: unsupported register sizes");
  end

  // ----------------------------------------------------------------
  // Test clock domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    tap_state_e tap;
    logic rti_done;
    logic [`IR_W-1:0] ir_sh;
    logic [`IR_W-1:0] ir;
    logic byp;
    logic [`ID_W-1:0] id_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_upd;
    logic upd_tgl;
    logic [ISP_LEN-1:0] isp_sh;
    logic isp_on;
    logic [ROWS-1:0][ROW_W-1:0] nv;
  } tck_st_s;

  typedef struct packed {
    logic tgl_seen;
    logic [BSR_LEN-1:0] latch;
    logic pin_test_mode;
    logic isp_active;
    logic [BSR_LEN-1:0] sys_out;
    logic [BSR_LEN-1:0] sys_oe;
    logic [BSR_LEN-1:0] core_in;
    logic mc_out;
  } core_st_s;

  tck_st_s t_r;
  tck_st_s t_nxt;
  core_st_s c_r;
  core_st_s c_nxt;
  logic [1:0] rp_q;
  logic [2*BSR_LEN-1:0] smp_q;
  logic [BSR_LEN+4:0] cx_q;
  logic rst_tck;
  logic port_en_t;
  logic [BSR_LEN-1:0] pin_t;
  logic [BSR_LEN-1:0] uout_t;
  logic port_on;
  logic rti_go;
  logic ser_bit;
  logic tdo_r;
  logic tdo_oe_r;
  logic [ADDR_W-1:0] isp_addr;
  logic [ROW_W-1:0] isp_data;
  dr_sel_e dr_sel;
  bs_mode_e mode_t;
  port_ctl_s ctl_t;
  port_ctl_s ctl_c;
  logic tgl_c;
  logic [BSR_LEN-1:0] pin_c;

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  // Power-up reset
  jtag_sync2 #(.W(2)) u_sync_rp (
    .clk(tck),
    .rst(1'b0),
    .d({sys_rst, port_en}),
    .q(rp_q)
  );
  jtag_sync2 #(.W(2 * BSR_LEN)) u_sync_smp (
    .clk(tck),
    .rst(rst_tck),
    .d({user_out, pin_in}),
    .q(smp_q)
  );
  jtag_sync2 #(.W(BSR_LEN + 5)) u_sync_core (
    .clk(core_clk),
    .rst(sys_rst),
    .d({ctl_t, t_r.upd_tgl, pin_in}),
    .q(cx_q)
  );

  assign rst_tck = rp_q[1];
  assign port_en_t = rp_q[0];
  assign uout_t = smp_q[2*BSR_LEN-1:BSR_LEN];
  assign pin_t = smp_q[BSR_LEN-1:0];
  assign ctl_c = port_ctl_s'(cx_q[BSR_LEN+4:BSR_LEN+1]);
  assign tgl_c = cx_q[BSR_LEN];
  assign pin_c = cx_q[BSR_LEN-1:0];

  // ----------------------------------------------------------------
  // Port ownership and instruction decode
  // ----------------------------------------------------------------
  // Reclaim pin and configuration choose owner
  assign port_on = port_en_t || !t_r.nv[`CFG_ROW][`CFG_IO_BIT];

  always_comb begin
    case (t_r.ir)
      `INS_IDCODE: dr_sel = DR_ID;
      `INS_SAMPLE, `INS_EXTEST, `INS_INTEST: dr_sel = DR_BSR;
      `INS_ISP_ENABLE, `INS_ISP_ERASE, `INS_ISP_PROGRAM, `INS_ISP_VERIFY,
      `INS_ISP_DISABLE: dr_sel = DR_ISP;
      default: dr_sel = DR_BYP;
    endcase
  end

  always_comb begin
    if (!port_on) begin
      mode_t = BS_FUNC;
    end else if (t_r.ir == `INS_HIGHZ) begin
      mode_t = BS_HIGHZ;
    end else if (t_r.ir == `INS_EXTEST || t_r.isp_on) begin
      mode_t = BS_DRIVE;
    end else if (t_r.ir == `INS_INTEST) begin
      mode_t = BS_INTEST;
    end else begin
      mode_t = BS_FUNC;
    end
  end

  assign ctl_t = '{mode: mode_t, isp_on: t_r.isp_on, port_on: port_on};
  assign rti_go = (t_r.tap == RTI) && !t_r.rti_done;
  assign isp_addr = t_r.isp_sh[ISP_LEN-1 -: ADDR_W];
  assign isp_data = t_r.isp_sh[ROW_W-1:0];

  // ----------------------------------------------------------------
  // Controller sequence
  // ----------------------------------------------------------------
  function automatic tap_state_e tap_next(tap_state_e s, logic m);
    case (s)
      TLR: tap_next = m ? TLR : RTI;
      RTI: tap_next = m ? SEL_DR : RTI;
      SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = m ? EX1_DR : SH_DR;
      SH_DR: tap_next = m ? EX1_DR : SH_DR;
      EX1_DR: tap_next = m ? UP_DR : PA_DR;
      PA_DR: tap_next = m ? EX2_DR : PA_DR;
      EX2_DR: tap_next = m ? UP_DR : SH_DR;
      UP_DR: tap_next = m ? SEL_DR : RTI;
      SEL_IR: tap_next = m ? TLR : CAP_IR;
      CAP_IR: tap_next = m ? EX1_IR : SH_IR;
      SH_IR: tap_next = m ? EX1_IR : SH_IR;
      EX1_IR: tap_next = m ? UP_IR : PA_IR;
      PA_IR: tap_next = m ? EX2_IR : PA_IR;
      EX2_IR: tap_next = m ? UP_IR : SH_IR;
      UP_IR: tap_next = m ? SEL_DR : RTI;
      default: tap_next = TLR;
    endcase
  endfunction : tap_next

  // ----------------------------------------------------------------
  // Test clock logic
  // ----------------------------------------------------------------
  always_comb begin
    t_nxt = t_r;
    // Mode select and data taken on rising edge
    t_nxt.tap = tap_next(t_r.tap, tms);
    case (t_r.tap)
      CAP_IR: t_nxt.ir_sh = `IR_CAPTURE;
      // Constant high input shifts in all ones
      SH_IR: t_nxt.ir_sh = {tdi, t_r.ir_sh[`IR_W-1:1]};
      UP_IR: begin
        t_nxt.ir = t_r.ir_sh;
        if (t_r.ir_sh == `INS_ISP_ENABLE) begin
          t_nxt.isp_on = 1'b1;
        end
        if (t_r.ir_sh == `INS_ISP_DISABLE) begin
          t_nxt.isp_on = 1'b0;
        end
      end
      CAP_DR: begin
        t_nxt.byp = 1'b0;
        t_nxt.id_sh = IDCODE;
        // Snapshot of pins or of core outputs
        t_nxt.bsr_sh = (t_r.ir == `INS_INTEST) ? uout_t : pin_t;
      end
      SH_DR: begin
        case (dr_sel)
          DR_ID: t_nxt.id_sh = {tdi, t_r.id_sh[`ID_W-1:1]};
          DR_BSR: t_nxt.bsr_sh = {tdi, t_r.bsr_sh[BSR_LEN-1:1]};
          DR_ISP: t_nxt.isp_sh = {tdi, t_r.isp_sh[ISP_LEN-1:1]};
          default: t_nxt.byp = tdi;
        endcase
      end
      UP_DR: begin
        // Preload of the parallel output latches
        if (dr_sel == DR_BSR) begin
          t_nxt.bsr_upd = t_r.bsr_sh;
          t_nxt.upd_tgl = !t_r.upd_tgl;
        end
      end
      default: begin
      end
    endcase
    t_nxt.rti_done = (t_r.tap == RTI);
    if (rti_go && t_r.isp_on) begin
      case (t_r.ir)
        `INS_ISP_ERASE: t_nxt.nv = '0;
        // Shift register written to addressed row
        `INS_ISP_PROGRAM: t_nxt.nv[isp_addr] = isp_data;
        // Addressed row copied for read back
        `INS_ISP_VERIFY: t_nxt.isp_sh[ROW_W-1:0] = t_r.nv[isp_addr];
        default: begin
        end
      endcase
    end
    if (t_r.tap == TLR) begin
      t_nxt.ir = `INS_IDCODE;
      t_nxt.isp_on = 1'b0;
    end
    // Port activity ignored while pins serve as I/O
    if (!port_on) begin
      t_nxt.tap = TLR;
      t_nxt.ir = `INS_IDCODE;
      t_nxt.isp_on = 1'b0;
    end
    // Power-up reset returns controller to reset state
    if (rst_tck) begin
      t_nxt = '0;
      t_nxt.tap = TLR;
      t_nxt.ir = `INS_IDCODE;
    end
  end

  always_ff @(posedge tck) begin
    t_r <= t_nxt;
  end

  // ----------------------------------------------------------------
  // Serial output on falling edge
  // ----------------------------------------------------------------
  always_comb begin
    case (dr_sel)
      DR_ID: ser_bit = t_r.id_sh[0];
      DR_BSR: ser_bit = t_r.bsr_sh[0];
      DR_ISP: ser_bit = t_r.isp_sh[0];
      default: ser_bit = t_r.byp;
    endcase
    if (t_r.tap == SH_IR) begin
      ser_bit = t_r.ir_sh[0];
    end
  end

  always_ff @(negedge tck) begin
    if (rst_tck) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r <= ser_bit;
      tdo_oe_r <= port_on && (t_r.tap == SH_DR || t_r.tap == SH_IR);
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe = tdo_oe_r;

  // ----------------------------------------------------------------
  // Core clock pin logic
  // ----------------------------------------------------------------
  always_comb begin
    c_nxt = c_r;
    if (tgl_c != c_r.tgl_seen) begin
      c_nxt.tgl_seen = tgl_c;
      c_nxt.latch = t_r.bsr_upd;
    end
    c_nxt.pin_test_mode = ctl_c.port_on;
    c_nxt.isp_active = ctl_c.isp_on;
    // Buried logic keeps running in test role
    c_nxt.mc_out = mc_logic_in;
    c_nxt.core_in = pin_c;
    case (ctl_c.mode)
      BS_DRIVE: begin
        c_nxt.sys_out = c_r.latch;
        c_nxt.sys_oe = '1;
      end
      BS_HIGHZ: begin
        c_nxt.sys_out = '0;
        c_nxt.sys_oe = '0;
      end
      BS_INTEST: begin
        c_nxt.sys_out = c_r.latch;
        c_nxt.sys_oe = '1;
        c_nxt.core_in = c_r.latch;
      end
      default: begin
        c_nxt.sys_out = user_out;
        c_nxt.sys_oe = user_oe;
      end
    endcase
    if (sys_rst) begin
      c_nxt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    c_r <= c_nxt;
  end

  assign pin_test_mode = c_r.pin_test_mode;
  assign isp_active = c_r.isp_active;
  assign sys_out = c_r.sys_out;
  assign sys_oe = c_r.sys_oe;
  assign core_in = c_r.core_in;
  assign mc_logic_out = c_r.mc_out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_ones_in;
    (t_r.tap == SH_IR && tdi) [*5];
  endsequence

  sequence seq_prog_go;
    rti_go && t_r.isp_on && t_r.ir == `INS_ISP_PROGRAM;
  endsequence

  sequence seq_erase_go;
    rti_go && t_r.isp_on && t_r.ir == `INS_ISP_ERASE;
  endsequence

  ir_capture_a: assert property (@(posedge tck) disable iff (rst_tck)
    t_r.tap == CAP_IR && port_on |=> t_r.ir_sh == `IR_CAPTURE)
    else $error("instruction capture value wrong");
  ones_bypass_a: assert property (@(posedge tck) disable iff (rst_tck)
    seq_ones_in |=> t_r.ir_sh == `INS_BYPASS)
    else $error("all-ones scan did not give bypass");
  bypass_path_a: assert property (@(posedge tck) disable iff (rst_tck)
    t_r.tap == SH_DR && t_r.ir == `INS_BYPASS && port_on |=> t_r.byp == $past(tdi))
    else $error("bypass bit not passed");
  idcode_load_a: assert property (@(posedge tck) disable iff (rst_tck)
    t_r.tap == CAP_DR && t_r.ir == `INS_IDCODE && port_on |=> t_r.id_sh == IDCODE)
    else $error("identification value not loaded");
  highz_mode_a: assert property (@(posedge tck) disable iff (rst_tck)
    t_r.ir == `INS_HIGHZ && port_on |-> mode_t == BS_HIGHZ && dr_sel == DR_BYP)
    else $error("high-z instruction decode wrong");
  unknown_byp_a: assert property (@(posedge tck) disable iff (rst_tck)
    t_r.ir == 5'h1E |-> dr_sel == DR_BYP)
    else $error("unlisted code not bypassed");
  port_block_a: assert property (@(posedge tck) disable iff (rst_tck)
    !port_on |=> t_r.tap == TLR && !t_r.isp_on)
    else $error("port active while pins are I/O");
  preload_upd_a: assert property (@(posedge tck) disable iff (rst_tck)
    t_r.tap == UP_DR && t_r.ir == `INS_SAMPLE && port_on |=> t_r.bsr_upd == $past(t_r.bsr_sh))
    else $error("preload latches not updated");
  row_program_a: assert property (@(posedge tck) disable iff (rst_tck)
    seq_prog_go |=> t_r.nv[$past(isp_addr)] == $past(isp_data))
    else $error("row not programmed");
  array_erase_a: assert property (@(posedge tck) disable iff (rst_tck)
    seq_erase_go |=> t_r.nv == '0)
    else $error("array not erased");
  isp_exit_a: assert property (@(posedge tck) disable iff (rst_tck)
    t_r.tap == UP_IR && t_r.ir_sh == `INS_ISP_DISABLE && port_on
    |=> !t_r.isp_on && dr_sel == DR_ISP)
    else $error("disable did not leave programming mode");
endmodule : jtag_isp_test_port

// [jtag_host_model.sv]
// Programmer-side model driving the serial test port pins
`timescale 1ns/10ps
module jtag_host_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic oe_seen;
  logic q;

  // ----------------------------------------------------------------
  // Serial cycles, clock stands still between them
  // ----------------------------------------------------------------
  // Mode select high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    oe_seen = 1'b0;
  end

  task automatic tick(input logic m, input logic d, output logic t);
    tms = m;
    tdi = d;
    #6;
    t = tdo;
    oe_seen = tdo_oe;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask : tick

  task automatic idle(input int n);
    repeat (n) tick(1'b1, 1'b1, q);
  endtask : idle

  task automatic to_rti();
    idle(5);
    tick(1'b0, 1'b1, q);
  endtask : to_rti

  task automatic run();
    tick(1'b0, 1'b1, q);
  endtask : run

  task automatic shift_ir(input logic [4:0] code, output logic [4:0] cap);
    tick(1'b1, 1'b1, q);
    tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
    tick(1'b0, 1'b1, q);
    for (int i = 0; i < 5; i++) begin
      tick(i == 4, code[i], cap[i]);
    end
    tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask : shift_ir

  task automatic shift_dr(input int n, input logic [31:0] din, output logic [31:0] dout,
                          output logic [5:0] cnt);
    dout = '0;
    cnt = '0;
    tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
    tick(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], dout[i]);
      cnt = cnt + 6'(oe_seen);
    end
    tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask : shift_dr
endmodule : jtag_host_model

// [tb_top.sv]
// Self-checking bench for the test access and programming port
`timescale 1ns/10ps
`include "jtag_isp_defines.svh"
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module tb_top;
  localparam int BSR = `BSR_LEN_DEF;
  localparam int ROW = `ROW_W_DEF;
  localparam int ISP_W = `ADDR_W_DEF + `ROW_W_DEF;
  logic core_clk = 1'b0;
  logic sys_rst;
  logic port_en;
  logic mc_logic_in;
  logic [BSR-1:0] user_out, user_oe, pin_in, sys_out, sys_oe, core_in;
  logic tck, tms, tdi, tdo, tdo_oe, pin_test_mode, isp_active, mc_logic_out;
  logic [31:0] d, p;
  logic [ROW-1:0] w, row;
  logic [2:0] a;
  logic [5:0] cnt;
  logic [4:0] codes [5] = '{5'h1F, `INS_HIGHZ, 5'h04, 5'h1E, 5'h07};
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  always #4 core_clk = ~core_clk;

  jtag_isp_test_port i_jtag_isp_test_port (.core_clk(core_clk), .sys_rst(sys_rst),
    .tck(tck), .tms(tms), .tdi(tdi), .port_en(port_en), .user_out(user_out),
    .user_oe(user_oe), .pin_in(pin_in), .mc_logic_in(mc_logic_in), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_test_mode(pin_test_mode), .isp_active(isp_active),
    .sys_out(sys_out), .sys_oe(sys_oe), .core_in(core_in), .mc_logic_out(mc_logic_out));
  jtag_host_model i_jtag_host_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [BSR-1:0] byp_exp(input logic [BSR-1:0] v);
    return {v[BSR-2:0], 1'b0};
  endfunction : byp_exp

  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic ld(input logic [4:0] code);
    logic [4:0] cap;
    i_jtag_host_model.shift_ir(code, cap);
    `CHK("ir capture", `IR_CAPTURE, cap);
  endtask : ld

  task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic [5:0] c;
    i_jtag_host_model.shift_dr(n, din, dout, c);
    `CHK("tdo enable count", 6'(n), c);
    `CHK("tdo enable idle", 1'b0, i_jtag_host_model.oe_seen);
  endtask : dr

  task automatic settle();
    repeat (8) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic set_ins();
    @(posedge core_clk);
    #1;
    user_out = BSR'($urandom);
    user_oe = BSR'($urandom);
    pin_in = BSR'($urandom);
    mc_logic_in = 1'($urandom);
  endtask : set_ins

  task automatic set_port(input logic v);
    @(posedge core_clk);
    #1;
    port_en = v;
    i_jtag_host_model.to_rti();
  endtask : set_port

  task automatic prog(input logic [2:0] ad, input logic [ROW-1:0] val);
    logic [31:0] x;
    ld(`INS_ISP_PROGRAM);
    dr(ISP_W, 32'({ad, val}), x);
    i_jtag_host_model.run();
  endtask : prog

  task automatic vfy(input logic [2:0] ad, output logic [ROW-1:0] val);
    logic [31:0] x;
    ld(`INS_ISP_VERIFY);
    dr(ISP_W, 32'({ad, ROW'(0)}), x);
    i_jtag_host_model.run();
    dr(ISP_W, 32'({ad, ROW'(0)}), x);
    val = x[ROW-1:0];
  endtask : vfy

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h364F0AC3));
    sys_rst = 1'b1;
    port_en = 1'b0;
    user_out = '0;
    user_oe = '0;
    pin_in = '0;
    mc_logic_in = 1'b0;
    fork
      begin
        repeat (4) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
      end
      i_jtag_host_model.idle(8);
    join
    i_jtag_host_model.to_rti();
    dr(32, '0, d);
    `CHK("idcode", `IDCODE_DEF, d);
    settle();
    `CHK("port in test", 1'b1, pin_test_mode);
    set_ins();
    settle();
    `CHK("user drive", user_out, sys_out);
    `CHK("user enable", user_oe, sys_oe);
    `CHK("buried cell", mc_logic_in, mc_logic_out);
    foreach (codes[k]) begin
      ld(codes[k]);
      p = $urandom;
      dr(BSR, p, d);
      `CHK("bypass path", byp_exp(p[BSR-1:0]), d[BSR-1:0]);
      if (codes[k] == `INS_HIGHZ) begin
        settle();
        `CHK("floated outputs", {BSR{1'b0}}, sys_oe);
      end
    end
    set_ins();
    ld(`INS_SAMPLE);
    p = $urandom;
    dr(BSR, p, d);
    `CHK("pin snapshot", pin_in, d[BSR-1:0]);
    ld(`INS_EXTEST);
    settle();
    `CHK("preload drive", p[BSR-1:0], sys_out);
    `CHK("preload enable", {BSR{1'b1}}, sys_oe);
    ld(`INS_INTEST);
    settle();
    `CHK("core stimulus", p[BSR-1:0], core_in);
    ld(`INS_ISP_ENABLE);
    settle();
    `CHK("isp mode", 1'b1, isp_active);
    `CHK("isp pin drive", p[BSR-1:0], sys_out);
    a = 3'($urandom_range(7, 1));
    w = ROW'($urandom);
    prog(a, w);
    vfy(a, row);
    `CHK("row readback", w, row);
    ld(`INS_ISP_ERASE);
    i_jtag_host_model.run();
    vfy(a, row);
    `CHK("erased row", {ROW{1'b0}}, row);
    set_port(1'b1);
    ld(`INS_ISP_ENABLE);
    settle();
    `CHK("isp mode again", 1'b1, isp_active);
    prog(3'h0, ROW'(1));
    ld(`INS_ISP_DISABLE);
    settle();
    `CHK("isp left", 1'b0, isp_active);
    dr(ISP_W, '0, d);
    `CHK("isp path", 32'(ROW'(1)), d);
    set_port(1'b0);
    settle();
    `CHK("pins as user io", 1'b0, pin_test_mode);
    i_jtag_host_model.to_rti();
    i_jtag_host_model.shift_dr(BSR, '1, d, cnt);
    `CHK("port ignored", 6'h00, cnt);
    set_port(1'b1);
    settle();
    `CHK("port reclaimed", 1'b1, pin_test_mode);
    i_jtag_host_model.to_rti();
    dr(32, '0, d);
    `CHK("idcode reclaimed", `IDCODE_DEF, d);
    set_port(1'b0);
    set_ins();
    settle();
    `CHK("port released", 1'b0, pin_test_mode);
    `CHK("user drive back", user_out, sys_out);
    wrap_up();
  end
endmodule : tb_top
